// ==== sbc_strap_sideband.sv ====
// Strap capture, serial port pin steering, GPIO, wake and boundary-scan top
//
// Overview of operation
// - Interface-select level is captured, not followed
// - EEPROM mode drives serial clock pin out
// - SMBus mode: clock pin input, host clocks
// - EEPROM mode: data pin driven or released
// - SMBus mode: data pin open drain only
// - Four GPIO pins, direction per enable bit
// - Wake asserted on power event during L2
// - TAP state advances on TMS at TCK
// - Scan data shifts TDI in, TDO out
// - Configuration access uses I2C or SMBus protocol
`include "sbc_map.svh"
module sbc_strap_sideband
	import sbc_pkg::*;
#(
	parameter int GPIO_W = `SBC_GPIO_COUNT
)(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// Mode straps
	input wire logic iface_select_strap_i,
	input wire logic operating_mode_strap_i,
	// EEPROM master engine
	input wire logic ee_scl_out_i,
	input wire logic ee_sda_out_i,
	input wire logic ee_sda_drive_i,
	// SMBus slave engine
	input wire logic smb_sda_pull_low_i,
	// Serial port pins
	input wire logic serial_clock_pin_i,
	input wire logic serial_data_pin_i,
	output logic serial_clock_pin_o,
	output logic serial_clock_pin_oe_n_o,
	output logic serial_data_pin_o,
	output logic serial_data_pin_oe_n_o,
	// Serial port state toward the engines
	output logic mode_valid_o,
	output logic ee_enable_o,
	output logic smb_enable_o,
	output logic mode_reserved_o,
	output logic serial_clock_in_o,
	output logic serial_data_in_o,
	// General-purpose pins
	input wire logic [GPIO_W-1:0] gpio_oe_ctrl_i,
	input wire logic [GPIO_W-1:0] gpio_out_ctrl_i,
	input wire logic [GPIO_W-1:0] gpio_pin_i,
	output logic [GPIO_W-1:0] gpio_pin_o,
	output logic [GPIO_W-1:0] gpio_pin_oe_n_o,
	output logic [GPIO_W-1:0] gpio_in_o,
	// Power management
	input wire logic power_event_in_n_i,
	input wire logic link_in_l2_i,
	output logic wake_n_o,
	// Boundary scan
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o
);
	sbc_mode_t mode_reg, mode_next;
	logic taken_reg, taken_next;
	logic ee_en_reg, ee_en_next, smb_en_reg, smb_en_next;
	sbc_pin_t scl_reg, scl_next, sda_reg, sda_next;
	logic scl_in_reg, scl_in_next, sda_in_reg, sda_in_next;
	logic [GPIO_W-1:0] gpio_out_reg, gpio_out_next, gpio_oe_n_reg, gpio_oe_n_next;
	logic [GPIO_W-1:0] gpio_in_reg, gpio_in_next;
	logic wake_n_reg, wake_n_next;
	logic tck_reg, tck_rise, tck_fall;

	//////////////////////////////////////////////////////////////////////////
	// Strap capture on the first cycle after reset release
	always_comb
	begin
		mode_next = mode_reg;
		taken_next = 1'h1;
		if (!taken_reg)
		begin
			mode_next.smbus = iface_select_strap_i;
			mode_next.reserved = operating_mode_strap_i;
		end
		// Mode enables registered from the values the strap flops take
		ee_en_next = taken_next && !mode_next.smbus;
		smb_en_next = taken_next && mode_next.smbus;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			mode_reg <= '{smbus: `SBC_STRAP_RESET, reserved: `SBC_STRAP_RESET};
			taken_reg <= 1'h0;
			ee_en_reg <= 1'h0;
			smb_en_reg <= 1'h0;
		end
		else
		begin
			mode_reg <= mode_next;
			taken_reg <= taken_next;
			ee_en_reg <= ee_en_next;
			smb_en_reg <= smb_en_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Serial port pin steering; pins stay released until the straps are held
	always_comb
	begin
		scl_next = '{out: 1'h0, oe_n: `SBC_OE_N_RESET};
		sda_next = '{out: 1'h0, oe_n: `SBC_OE_N_RESET};
		if (taken_reg && !mode_reg.smbus)
		begin
			scl_next = '{out: ee_scl_out_i, oe_n: 1'h0};
			sda_next = '{out: ee_sda_out_i, oe_n: !ee_sda_drive_i};
		end
		else if (taken_reg)
		begin
			// Clock pin stays an input; data only ever pulls low
			sda_next = '{out: 1'h0, oe_n: !smb_sda_pull_low_i};
		end
		scl_in_next = serial_clock_pin_i;
		sda_in_next = serial_data_pin_i;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			scl_reg <= '{out: 1'h0, oe_n: `SBC_OE_N_RESET};
			sda_reg <= '{out: 1'h0, oe_n: `SBC_OE_N_RESET};
			scl_in_reg <= 1'h1;
			sda_in_reg <= 1'h1;
		end
		else
		begin
			scl_reg <= scl_next;
			sda_reg <= sda_next;
			scl_in_reg <= scl_in_next;
			sda_in_reg <= sda_in_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// General-purpose pins and wake
	always_comb
	begin
		gpio_out_next = gpio_out_ctrl_i;
		gpio_oe_n_next = ~gpio_oe_ctrl_i;
		gpio_in_next = gpio_pin_i;
		wake_n_next = !(!power_event_in_n_i && link_in_l2_i);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			gpio_out_reg <= '0;
			gpio_oe_n_reg <= '1;
			gpio_in_reg <= '0;
			wake_n_reg <= `SBC_WAKE_N_RESET;
		end
		else
		begin
			gpio_out_reg <= gpio_out_next;
			gpio_oe_n_reg <= gpio_oe_n_next;
			gpio_in_reg <= gpio_in_next;
			wake_n_reg <= wake_n_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Test clock edges, then the TAP
	always_ff @(posedge clk_sys_i)
	begin
		// Reset to the pulled-up idle level: no false rise after reset
		if (srst_i)
			tck_reg <= 1'h1;
		else
			tck_reg <= tck_i;
	end

	always_comb
	begin
		tck_rise = tck_i && !tck_reg;
		tck_fall = !tck_i && tck_reg;
	end

	sbc_tap #(
		.SAMPLE_W(GPIO_W + 2)
	) u_tap (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.tck_rise_i(tck_rise),
		.tck_fall_i(tck_fall),
		.tms_i(tms_i),
		.tdi_i(tdi_i),
		.sample_i({gpio_pin_i, serial_data_pin_i, serial_clock_pin_i}),
		.tdo_o(tdo_o)
	);

	//////////////////////////////////////////////////////////////////////////
	assign serial_clock_pin_o = scl_reg.out;
	assign serial_clock_pin_oe_n_o = scl_reg.oe_n;
	assign serial_data_pin_o = sda_reg.out;
	assign serial_data_pin_oe_n_o = sda_reg.oe_n;
	assign mode_valid_o = taken_reg;
	assign ee_enable_o = ee_en_reg;
	assign smb_enable_o = smb_en_reg;
	assign mode_reserved_o = mode_reg.reserved;
	assign serial_clock_in_o = scl_in_reg;
	assign serial_data_in_o = sda_in_reg;
	assign gpio_pin_o = gpio_out_reg;
	assign gpio_pin_oe_n_o = gpio_oe_n_reg;
	assign gpio_in_o = gpio_in_reg;
	assign wake_n_o = wake_n_reg;

	//////////////////////////////////////////////////////////////////////////
	default clocking cb_sys @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	a_strap_capture: assert property (!srst_i && !taken_reg |=> mode_reg.smbus == $past(iface_select_strap_i))
		else $error("Interface strap not captured at release");
	a_strap_hold: assert property (taken_reg |=> $stable(mode_reg) && taken_reg)
		else $error("Latched straps changed after capture");
	a_mode_select: assert property (taken_reg |-> ee_enable_o != smb_enable_o && smb_enable_o == mode_reg.smbus)
		else $error("Serial port mode does not match strap");
	a_scl_ee_drive: assert property (ee_enable_o |=> !serial_clock_pin_oe_n_o && serial_clock_pin_o == $past(ee_scl_out_i))
		else $error("Clock pin not driven in EEPROM mode");
	a_scl_smb_input: assert property (smb_enable_o |=> serial_clock_pin_oe_n_o)
		else $error("Clock pin driven in SMBus mode");
	a_sda_ee_drive: assert property (ee_enable_o |=> serial_data_pin_oe_n_o == !$past(ee_sda_drive_i) && serial_data_pin_o == $past(ee_sda_out_i))
		else $error("Data pin does not follow EEPROM engine");
	a_sda_open_drain: assert property (smb_enable_o ##1 !serial_data_pin_oe_n_o |-> !serial_data_pin_o)
		else $error("Data pin driven high in SMBus mode");
	a_gpio_direction: assert property (!srst_i |=> gpio_pin_oe_n_o == ~$past(gpio_oe_ctrl_i))
		else $error("GPIO direction does not follow enable bits");
	a_wake_assert: assert property ((!power_event_in_n_i && link_in_l2_i) |=> !wake_n_o)
		else $error("Wake not asserted on power event in L2");
	a_wake_release: assert property ((power_event_in_n_i || !link_in_l2_i) ##1 !srst_i |-> wake_n_o)
		else $error("Wake asserted without cause");
endmodule

// ==== sbc_map.svh ====
// Constants for the strap and sideband control block
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH
`define SBC_GPIO_COUNT 4
`define SBC_IR_WIDTH 4
`define SBC_IR_CAPTURE 4'h1
`define SBC_IR_BYPASS 4'hF
`define SBC_IR_SAMPLE 4'h2
`define SBC_STRAP_RESET 1'h0
`define SBC_WAKE_N_RESET 1'h1
`define SBC_OE_N_RESET 1'h1
`endif

// ==== sbc_pkg.sv ====
// Types shared by the strap and sideband control block
package sbc_pkg;
	// Latched strap levels
	typedef struct packed {
		logic smbus;
		logic reserved;
	} sbc_mode_t;

	// One driven pin: level and active-low output enable
	typedef struct packed {
		logic out;
		logic oe_n;
	} sbc_pin_t;

	// Boundary-scan TAP controller states
	typedef enum logic [3:0] {
		SBC_TLR, SBC_RTI, SBC_SEL_DR, SBC_CAP_DR, SBC_SHIFT_DR, SBC_EXIT1_DR,
		SBC_PAUSE_DR, SBC_EXIT2_DR, SBC_UPD_DR, SBC_SEL_IR, SBC_CAP_IR,
		SBC_SHIFT_IR, SBC_EXIT1_IR, SBC_PAUSE_IR, SBC_EXIT2_IR, SBC_UPD_IR
	} sbc_tap_state_t;
endpackage

// ==== sbc_tap.sv ====
// Boundary-scan TAP controller with instruction, bypass and sample registers
`include "sbc_map.svh"
module sbc_tap
	import sbc_pkg::*;
#(
	parameter int SAMPLE_W = 6
)(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// Test clock edges and serial inputs
	input wire logic tck_rise_i,
	input wire logic tck_fall_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	input wire logic [SAMPLE_W-1:0] sample_i,
	// Serial output
	output logic tdo_o
);
	sbc_tap_state_t st_reg, st_next;
	logic [`SBC_IR_WIDTH-1:0] ir_reg, ir_next, instr_reg, instr_next;
	logic byp_reg, byp_next;
	logic [SAMPLE_W-1:0] smp_reg, smp_next;
	logic tdo_reg, tdo_next;

	//////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		st_next = st_reg;
		ir_next = ir_reg;
		instr_next = instr_reg;
		byp_next = byp_reg;
		smp_next = smp_reg;
		tdo_next = tdo_reg;
		if (tck_rise_i)
		begin
			// State walk follows the test mode select level
			case (st_reg)
				SBC_TLR: st_next = tms_i ? SBC_TLR : SBC_RTI;
				SBC_RTI: st_next = tms_i ? SBC_SEL_DR : SBC_RTI;
				SBC_SEL_DR: st_next = tms_i ? SBC_SEL_IR : SBC_CAP_DR;
				SBC_CAP_DR: st_next = tms_i ? SBC_EXIT1_DR : SBC_SHIFT_DR;
				SBC_SHIFT_DR: st_next = tms_i ? SBC_EXIT1_DR : SBC_SHIFT_DR;
				SBC_EXIT1_DR: st_next = tms_i ? SBC_UPD_DR : SBC_PAUSE_DR;
				SBC_PAUSE_DR: st_next = tms_i ? SBC_EXIT2_DR : SBC_PAUSE_DR;
				SBC_EXIT2_DR: st_next = tms_i ? SBC_UPD_DR : SBC_SHIFT_DR;
				SBC_UPD_DR: st_next = tms_i ? SBC_SEL_DR : SBC_RTI;
				SBC_SEL_IR: st_next = tms_i ? SBC_TLR : SBC_CAP_IR;
				SBC_CAP_IR: st_next = tms_i ? SBC_EXIT1_IR : SBC_SHIFT_IR;
				SBC_SHIFT_IR: st_next = tms_i ? SBC_EXIT1_IR : SBC_SHIFT_IR;
				SBC_EXIT1_IR: st_next = tms_i ? SBC_UPD_IR : SBC_PAUSE_IR;
				SBC_PAUSE_IR: st_next = tms_i ? SBC_EXIT2_IR : SBC_PAUSE_IR;
				SBC_EXIT2_IR: st_next = tms_i ? SBC_UPD_IR : SBC_SHIFT_IR;
				SBC_UPD_IR: st_next = tms_i ? SBC_SEL_DR : SBC_RTI;
				default: st_next = SBC_TLR;
			endcase
			// Registers capture, shift from the serial input and update
			case (st_reg)
				SBC_TLR: instr_next = `SBC_IR_BYPASS;
				SBC_CAP_IR: ir_next = `SBC_IR_CAPTURE;
				SBC_SHIFT_IR: ir_next = {tdi_i, ir_reg[`SBC_IR_WIDTH-1:1]};
				SBC_UPD_IR: instr_next = ir_reg;
				SBC_CAP_DR:
				begin
					byp_next = 1'h0;
					smp_next = sample_i;
				end
				SBC_SHIFT_DR:
				begin
					byp_next = tdi_i;
					smp_next = {tdi_i, smp_reg[SAMPLE_W-1:1]};
				end
				default: ;
			endcase
		end
		// Output changes on the falling test clock edge
		if (tck_fall_i)
		begin
			case (st_reg)
				SBC_SHIFT_IR: tdo_next = ir_reg[0];
				SBC_SHIFT_DR: tdo_next = (instr_reg == `SBC_IR_SAMPLE) ? smp_reg[0] : byp_reg;
				default: tdo_next = tdo_reg;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			st_reg <= SBC_TLR;
			ir_reg <= `SBC_IR_CAPTURE;
			instr_reg <= `SBC_IR_BYPASS;
			byp_reg <= 1'h0;
			smp_reg <= '0;
			tdo_reg <= 1'h0;
		end
		else
		begin
			st_reg <= st_next;
			ir_reg <= ir_next;
			instr_reg <= instr_next;
			byp_reg <= byp_next;
			smp_reg <= smp_next;
			tdo_reg <= tdo_next;
		end
	end

	assign tdo_o = tdo_reg;

	//////////////////////////////////////////////////////////////////////////
	a_tap_exit_reset: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(tck_rise_i && !tms_i && st_reg == SBC_TLR) |=> st_reg == SBC_RTI)
		else $error("TAP did not leave reset on low TMS");
	a_tap_bypass_out: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(tck_fall_i && st_reg == SBC_SHIFT_DR && instr_reg == `SBC_IR_BYPASS)
		|=> tdo_reg == $past(byp_reg))
		else $error("TDO does not follow bypass bit");
endmodule

// ==== sbc_far_side.sv ====
// Far-side model: serial EEPROM or SMBus host on pulled-up clock and data lines
module sbc_far_side (
	// Mode of the far side: high = SMBus host supplies the clock
	input wire logic host_en_i,
	input wire logic host_scl_i,
	input wire logic far_sda_low_i,
	// Device pins
	input wire logic dev_scl_i,
	input wire logic dev_scl_oe_n_i,
	input wire logic dev_sda_i,
	input wire logic dev_sda_oe_n_i,
	// Resolved line levels
	output logic scl_o,
	output logic sda_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic scl_far;
	// Host clocks the line only in SMBus mode; a released line floats high
	assign scl_far = host_en_i ? host_scl_i : 1'h1;
	assign scl_o = (dev_scl_oe_n_i ? 1'h1 : dev_scl_i) & scl_far;
	// Far side pulls data low only, never drives it high
	assign sda_o = (dev_sda_oe_n_i ? 1'h1 : dev_sda_i) & ~far_sda_low_i;
endmodule

// ==== tb_strap_and_sideband_control.sv ====
// Testbench for the strap and sideband control block
module tb_strap_and_sideband_control;
	timeunit 1ns;
	timeprecision 1ps;
	import sbc_pkg::*;
	logic clk_sys_i = 0, srst_i = 1, strap = 0, op_strap = 0;
	logic ee_scl = 0, ee_sda = 0, ee_drv = 0, smb_low = 0;
	logic host_en = 0, host_scl = 1, far_low = 0;
	logic pme_n = 1, l2 = 0, tck = 0, tms = 1, tdi = 0;
	logic [3:0] g_oe = 4'h0, g_out = 4'h0, g_ext = 4'h3, g_pin;
	logic scl_w, sda_w, scl_o, scl_oe_n, sda_o, sda_oe_n;
	logic mode_valid, ee_en, smb_en, mode_res, scl_in, sda_in, wake_n, tdo;
	logic [3:0] gpio_o, gpio_oe_n, gpio_in;
	int errors = 0;
	int checks = 0;
	int cycles = 0;

	////////////////////////////////////////////////////////////////////////
	initial forever #2.5 clk_sys_i = ~clk_sys_i;
	assign g_pin = (gpio_oe_n & g_ext) | (~gpio_oe_n & gpio_o);

	sbc_far_side far (.host_en_i(host_en), .host_scl_i(host_scl), .far_sda_low_i(far_low),
		.dev_scl_i(scl_o), .dev_scl_oe_n_i(scl_oe_n), .dev_sda_i(sda_o),
		.dev_sda_oe_n_i(sda_oe_n), .scl_o(scl_w), .sda_o(sda_w));

	sbc_strap_sideband dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.iface_select_strap_i(strap), .operating_mode_strap_i(op_strap),
		.ee_scl_out_i(ee_scl), .ee_sda_out_i(ee_sda), .ee_sda_drive_i(ee_drv),
		.smb_sda_pull_low_i(smb_low), .serial_clock_pin_i(scl_w), .serial_data_pin_i(sda_w),
		.serial_clock_pin_o(scl_o), .serial_clock_pin_oe_n_o(scl_oe_n),
		.serial_data_pin_o(sda_o), .serial_data_pin_oe_n_o(sda_oe_n),
		.mode_valid_o(mode_valid), .ee_enable_o(ee_en), .smb_enable_o(smb_en),
		.mode_reserved_o(mode_res), .serial_clock_in_o(scl_in), .serial_data_in_o(sda_in),
		.gpio_oe_ctrl_i(g_oe), .gpio_out_ctrl_i(g_out), .gpio_pin_i(g_pin),
		.gpio_pin_o(gpio_o), .gpio_pin_oe_n_o(gpio_oe_n), .gpio_in_o(gpio_in),
		.power_event_in_n_i(pme_n), .link_in_l2_i(l2), .wake_n_o(wake_n),
		.tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic do_reset(input logic s, input logic h);
		@(posedge clk_sys_i);
		srst_i <= 1'h1;
		strap <= s;
		host_en <= h;
		op_strap <= 1'h0;
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 1'h0;
		step(3);
	endtask

	task automatic t_eeprom;
		do_reset(1'h0, 1'h0);
		chk("ee_en", 4'h1, {3'h0, ee_en});
		chk("mode", 4'h2, {2'h0, mode_valid, smb_en});
		chk("mode_res", 4'h0, {3'h0, mode_res});
		@(posedge clk_sys_i);
		ee_scl <= 1'h1;
		ee_drv <= 1'h1;
		strap <= 1'h1;
		step(3);
		chk("ee_held", 4'h1, {3'h0, ee_en});
		chk("smb_held", 4'h0, {3'h0, smb_en});
		chk("scl_drv", 4'h1, {2'h0, scl_oe_n, scl_o});
		chk("sda_drv", 4'h0, {1'h0, sda_oe_n, sda_o, sda_in});
		@(posedge clk_sys_i);
		ee_scl <= 1'h0;
		ee_drv <= 1'h0;
		far_low <= 1'h1;
		step(3);
		chk("scl_low", 4'h0, {2'h0, scl_o, scl_in});
		chk("sda_rel", 4'h4, {1'h0, sda_oe_n, 1'h0, sda_in});
		@(posedge clk_sys_i);
		far_low <= 1'h0;
		step(3);
		chk("sda_pull", 4'h1, {3'h0, sda_in});
	endtask

	task automatic t_smbus;
		do_reset(1'h1, 1'h1);
		chk("smb_en", 4'h1, {2'h0, ee_en, smb_en});
		@(posedge clk_sys_i);
		host_scl <= 1'h0;
		ee_scl <= 1'h1;
		ee_drv <= 1'h1;
		ee_sda <= 1'h1;
		strap <= 1'h0;
		step(3);
		chk("scl_in0", 4'h2, {2'h0, scl_oe_n, scl_in});
		chk("sda_nohi", 4'h1, {2'h0, sda_o, sda_oe_n});
		chk("smb_held", 4'h1, {3'h0, smb_en});
		@(posedge clk_sys_i);
		host_scl <= 1'h1;
		smb_low <= 1'h1;
		step(3);
		chk("scl_in1", 4'h3, {2'h0, scl_oe_n, scl_in});
		chk("sda_pull", 4'h0, {1'h0, sda_o, sda_oe_n, sda_in});
		@(posedge clk_sys_i);
		smb_low <= 1'h0;
		ee_drv <= 1'h0;
		step(3);
		chk("sda_rel", 4'h3, {2'h0, sda_oe_n, sda_in});
	endtask

	task automatic t_gpio;
		@(posedge clk_sys_i);
		g_oe <= 4'h5;
		g_out <= 4'hF;
		step(3);
		chk("gpio_oe_n", 4'hA, gpio_oe_n);
		chk("gpio_out", 4'h5, gpio_o & 4'h5);
		chk("gpio_in", 4'h7, gpio_in);
	endtask

	task automatic t_wake;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_sys_i);
			pme_n <= i[0];
			l2 <= i[1];
			step(2);
			chk("wake_n", (i == 2) ? 4'h0 : 4'h1, {3'h0, wake_n});
		end
	endtask

	task automatic tck_pulse(input logic m, input logic d);
		@(posedge clk_sys_i);
		tms <= m;
		tdi <= d;
		@(posedge clk_sys_i);
		tck <= 1'h1;
		step(2);
		@(posedge clk_sys_i);
		tck <= 1'h0;
		step(3);
	endtask

	// Walks the TAP with the low n bits of seq, most significant first
	task automatic tms_walk(input logic [15:0] seq, input int n);
		for (int i = n - 1; i >= 0; i--)
			tck_pulse(seq[i], 1'h0);
	endtask

	task automatic t_tap;
		logic [6:0] exp;
		// Sample chain {gpio 4'h7, data 1, clock 1}, then a shifted-in one
		exp = 7'h5F;
		// Reset state, then into the data shift state under bypass
		tms_walk(16'h01F4, 9);
		chk("tdo_byp0", 4'h0, {3'h0, tdo});
		tck_pulse(1'h0, 1'h1);
		chk("tdo_byp1", 4'h1, {3'h0, tdo});
		// Out of the data path and into the instruction shift state
		tms_walk(16'h003C, 6);
		chk("tdo_ir_cap", 4'h1, {3'h0, tdo});
		for (int i = 0; i < 4; i++)
		begin
			// Shift in the sample instruction, leaving on the last bit
			tck_pulse(i == 3, i == 1);
			chk("tdo_ir", 4'h0, {3'h0, tdo});
		end
		// Update the instruction, then capture the sample chain
		tms_walk(16'h000A, 4);
		for (int i = 0; i < 7; i++)
		begin
			tck_pulse(1'h0, 1'h1);
			chk("tdo_smp", {3'h0, exp[i]}, {3'h0, tdo});
		end
	endtask

	task automatic results;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			results();
		end
	end

	initial
	begin
		t_eeprom();
		t_smbus();
		t_gpio();
		t_wake();
		t_tap();
		results();
	end
endmodule
